// ### hw/csp_pkg.sv
// Constants and carrier types for the clock source select and prescaler block.
// Assumes one 100 MHz clock domain; slow clocks arrive as pin levels and become one-cycle enables.
//
// Contract
// - System prescaler is a 13-bit up-counter advancing each system clock period.
// - Reset clears the system prescaler; counting starts when reset ends.
// - In standby, watch, subactive, subsleep the system prescaler stops at zero.
// - The system prescaler count is never readable or writable by software.
// - System prescaler taps are shared; each peripheral picks its own ratio.
// - In medium-speed mode the input is oscillator clock over 16, 32, 64 or 128.
// - Watch prescaler is a 5-bit counter clocked by the watch clock over four.
// - Reset clears the watch prescaler; counting starts when reset ends.
// - Watch prescaler keeps counting in low-power modes while the subclock runs.
// - Writing ones to both timebase-clear bits clears the watch prescaler.
// - Watch prescaler outputs feed timer A as its timekeeping base.
// - Select pin sampled in reset: 0 picks system oscillator, 1 on-chip one.
// - Watchdog or low-voltage resets keep the existing oscillator selection.
// - Setting the subclock-stop bit stops the subclock oscillator.
// - Subclock-stop bit is bit 7; it may be set only in active mode.
// - Bit 2 reports the select pin level latched during reset.
// - Bit 1 reads 1 when the on-chip oscillator runs, 0 otherwise.

package csp_pkg;

    localparam int SYS_PS_W            = 13;
    localparam int WATCH_PS_W          = 5;
    localparam int WATCH_PRE_DIV_W     = 2;
    localparam int MED_DIV_W           = 7;
    localparam logic [12:0] SYS_PS_RST = 13'h0000;
    localparam logic [4:0]  WATCH_PS_RST = 5'h00;
    localparam logic [1:0]  WATCH_PRE_RST = 2'h0;
    localparam logic [6:0]  MED_DIV_RST  = 7'h00;
    localparam int OSC_SUB_STOP_BIT    = 7;
    localparam int OSC_SELF_BIT        = 2;
    localparam int OSC_ONCHIP_BIT      = 1;
    localparam logic [7:0]  OSC_RST    = 8'h00;
    // Edges after reset release before both synchroniser stages hold the pin
    localparam logic [1:0]  SEL_LATCH_CNT = 2'h2;

    typedef enum logic [2:0] {
        CSP_ACTIVE_HI  = 3'b000,
        CSP_ACTIVE_MED = 3'b001,
        CSP_SLEEP      = 3'b010,
        CSP_STANDBY    = 3'b011,
        CSP_WATCH      = 3'b100,
        CSP_SUBACTIVE  = 3'b101,
        CSP_SUBSLEEP   = 3'b110
    } csp_mode_t;

    typedef enum logic [1:0] {
        CSP_MDIV16  = 2'b00,
        CSP_MDIV32  = 2'b01,
        CSP_MDIV64  = 2'b10,
        CSP_MDIV128 = 2'b11
    } csp_mdiv_t;

    typedef struct packed {
        logic [SYS_PS_W-1:0]   sys_taps;
        logic [SYS_PS_W-1:0]   sys_ticks;
        logic [WATCH_PS_W-1:0] watch_taps;
        logic [WATCH_PS_W-1:0] watch_ticks;
    } csp_taps_t;

endpackage : csp_pkg

// ### hw/csp_watch_ps.sv
// Watch prescaler: subclock tick over four, then a 5-bit ripple-free counter.
// Assumes watch_tick is a synchronised one-cycle enable per subclock period.
`timescale 1ns/1ns

module csp_watch_ps
    import csp_pkg::*;
(
    input  wire logic                  clk,          // 100 MHz clock
    input  wire logic                  rst_n,        // Async reset, active low
    input  wire logic                  watch_tick,   // One subclock period elapsed
    input  wire logic                  tb_clear,     // Both timebase-clear bits written
    output logic [WATCH_PS_W-1:0]      count,        // Watch prescaler count
    output logic [WATCH_PS_W-1:0]      ticks         // Per-tap rising-edge enables
);

    typedef struct packed {
        logic [WATCH_PRE_DIV_W-1:0] pre;
        logic [WATCH_PS_W-1:0]      cnt;
        logic [WATCH_PS_W-1:0]      tk;
    } csp_wst_t;

    csp_wst_t st_q;
    csp_wst_t st_d;
    logic     quarter;

    always_comb begin
        st_d    = st_q;
        st_d.tk = '0;
        quarter = 1'b0;
        if (watch_tick) begin
            st_d.pre = st_q.pre + 2'h1;
            quarter  = (st_q.pre == 2'h3);
        end
        if (tb_clear) begin
            st_d.pre = WATCH_PRE_RST;
            st_d.cnt = WATCH_PS_RST;
        end else if (quarter) begin
            st_d.cnt = st_q.cnt + 5'h01;
            st_d.tk  = st_d.cnt & ~st_q.cnt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{pre: WATCH_PRE_RST, cnt: WATCH_PS_RST, tk: 5'h00};
        end else begin
            st_q <= st_d;
        end
    end

    assign count = st_q.cnt;
    assign ticks = st_q.tk;

    property p_wclr;
        @(posedge clk) disable iff (!rst_n) tb_clear |=> (count == 5'h00);
    endproperty
    a_wclr: assert property (p_wclr) else $error("watch prescaler not cleared");

    property p_wstep;
        @(posedge clk) disable iff (!rst_n)
            (watch_tick && st_q.pre == 2'h3 && !tb_clear)
            |=> (count == 5'($past(count) + 5'h01));
    endproperty
    a_wstep: assert property (p_wstep) else $error("watch prescaler missed a step");

    property p_whold;
        @(posedge clk) disable iff (!rst_n)
            (!watch_tick && !tb_clear) |=> $stable(count);
    endproperty
    a_whold: assert property (p_whold) else $error("watch prescaler moved without tick");

endmodule : csp_watch_ps

// ### hw/csp_top.sv
// Clock source select, subclock stop control and both prescalers.
// Assumes one 100 MHz clock; the oscillator and subclock arrive as pin levels
// that are synchronised here and turned into one-cycle enables.
`timescale 1ns/1ns

module csp_top
    import csp_pkg::*;
(
    input  wire logic          clk,             // 100 MHz clock
    input  wire logic          rst_n,           // Async reset, active low
    input  wire logic          rst_keep_sel,    // Reset cause is watchdog or low voltage
    input  wire logic          clock_select_pin,// Select pin, asynchronous
    input  wire logic          osc_clk_pin,     // Oscillator clock level, asynchronous
    input  wire logic          subclk_pin,      // Subclock level, asynchronous
    input  csp_mode_t          mode,            // Current operating mode
    input  csp_mdiv_t          med_div,         // Medium-speed divide selection
    input  wire logic          osc_wr,          // Oscillator control register write
    input  wire logic [7:0]    osc_wdata,       // Write data
    input  wire logic          timer_a_mode_wr, // Timer A mode register write
    input  wire logic [3:2]    timer_a_mode_wdata, // Timebase-clear bits hi, lo
    output logic [7:0]         oscillator_control_reg, // Read value
    output logic               sysosc_enable,   // System clock oscillator enabled
    output logic               onchip_osc_enable, // On-chip oscillator enabled
    output logic               subclk_osc_stop, // Subclock oscillator stopped
    output csp_taps_t          taps             // Prescaler taps and tick enables
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [1:0]            osc_sync;
        logic [1:0]            sub_sync;
        logic [1:0]            sel_sync;
        logic                  osc_prev;
        logic                  sub_prev;
        logic                  in_reset;
        logic [1:0]            rel_cnt;
        logic                  sel_lat;
        logic                  sub_stop;
        logic [5:3]            rsv;
        logic [MED_DIV_W-1:0]  mdiv;
        logic [SYS_PS_W-1:0]   sps;
        logic [SYS_PS_W-1:0]   stk;
    } csp_st_t;

    csp_st_t st_q;
    csp_st_t st_d;
    logic    osc_tick;
    logic    sub_tick;
    logic    sys_halt;
    logic    med_hit;
    logic    sys_adv;
    logic    tb_clear;
    logic [WATCH_PS_W-1:0] w_cnt;
    logic [WATCH_PS_W-1:0] w_tk;

    // ==========================================================
    // Next state
    always_comb begin
        st_d          = st_q;
        st_d.osc_sync = {st_q.osc_sync[0], osc_clk_pin};
        st_d.sub_sync = {st_q.sub_sync[0], subclk_pin};
        st_d.sel_sync = {st_q.sel_sync[0], clock_select_pin};
        st_d.osc_prev = st_q.osc_sync[1];
        st_d.sub_prev = st_q.sub_sync[1];
        st_d.stk      = '0;
        osc_tick      = st_q.osc_sync[1] && !st_q.osc_prev;
        sub_tick      = st_q.sub_sync[1] && !st_q.sub_prev && !st_q.sub_stop;
        sys_halt      = (mode == CSP_STANDBY) || (mode == CSP_WATCH)
                        || (mode == CSP_SUBACTIVE) || (mode == CSP_SUBSLEEP);
        unique case (med_div)
            CSP_MDIV16:  med_hit = (st_q.mdiv[3:0] == 4'hF);
            CSP_MDIV32:  med_hit = (st_q.mdiv[4:0] == 5'h1F);
            CSP_MDIV64:  med_hit = (st_q.mdiv[5:0] == 6'h3F);
            CSP_MDIV128: med_hit = (st_q.mdiv == 7'h7F);
        endcase
        sys_adv       = 1'b0;
        // Selection is caught once both synchroniser stages hold samples
        // taken after release; the reset clears them, so earlier is stale
        if (st_q.in_reset) begin
            st_d.rel_cnt = st_q.rel_cnt + 2'h1;
            if (st_q.rel_cnt == SEL_LATCH_CNT) begin
                st_d.in_reset = 1'b0;
                if (!rst_keep_sel) begin
                    st_d.sel_lat = st_q.sel_sync[1];
                end
            end
        end
        if (sys_halt) begin
            st_d.sps  = SYS_PS_RST;
            st_d.mdiv = MED_DIV_RST;
        end else if (mode == CSP_ACTIVE_MED) begin
            if (osc_tick) begin
                st_d.mdiv = st_q.mdiv + 7'h01;
                sys_adv   = med_hit;
            end
        end else begin
            st_d.mdiv = MED_DIV_RST;
            sys_adv   = 1'b1;
        end
        if (sys_adv) begin
            st_d.sps = st_q.sps + 13'h0001;
            st_d.stk = st_d.sps & ~st_q.sps;
        end
        if (osc_wr) begin
            // Stop may be set only in active mode; clearing is always allowed
            if (!osc_wdata[OSC_SUB_STOP_BIT]
                || mode == CSP_ACTIVE_HI || mode == CSP_ACTIVE_MED) begin
                st_d.sub_stop = osc_wdata[OSC_SUB_STOP_BIT];
            end
            st_d.rsv = osc_wdata[5:3];
        end
        tb_clear = timer_a_mode_wr && (timer_a_mode_wdata == 2'b11);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Latched selection has no reset so a watchdog or low-voltage
            // reset keeps it; it is undefined until the first latch
            st_q.osc_sync <= 2'h0;
            st_q.sub_sync <= 2'h0;
            st_q.sel_sync <= 2'h0;
            st_q.osc_prev <= 1'b0;
            st_q.sub_prev <= 1'b0;
            st_q.in_reset <= 1'b1;
            st_q.rel_cnt  <= 2'h0;
            st_q.sub_stop <= OSC_RST[OSC_SUB_STOP_BIT];
            st_q.rsv      <= OSC_RST[5:3];
            st_q.mdiv     <= MED_DIV_RST;
            st_q.sps      <= SYS_PS_RST;
            st_q.stk      <= SYS_PS_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Watch prescaler
    csp_watch_ps u_watch (
        .clk        (clk),
        .rst_n      (rst_n),
        .watch_tick (sub_tick),
        .tb_clear   (tb_clear),
        .count      (w_cnt),
        .ticks      (w_tk)
    );

    // ==========================================================
    // Outputs; the system count leaves only as taps, never on a read path
    always_comb begin
        oscillator_control_reg                 = OSC_RST;
        oscillator_control_reg[OSC_SUB_STOP_BIT] = st_q.sub_stop;
        oscillator_control_reg[5:3]            = st_q.rsv;
        oscillator_control_reg[OSC_SELF_BIT]   = st_q.sel_lat;
        oscillator_control_reg[OSC_ONCHIP_BIT] = st_q.sel_lat;
    end

    assign sysosc_enable     = !st_q.sel_lat;
    assign onchip_osc_enable = st_q.sel_lat;
    assign subclk_osc_stop   = st_q.sub_stop;
    assign taps = '{sys_taps: st_q.sps, sys_ticks: st_q.stk,
                    watch_taps: w_cnt, watch_ticks: w_tk};

    // ==========================================================
    // Checks
    property p_halt_zero;
        @(posedge clk) disable iff (!rst_n) sys_halt |=> (st_q.sps == 13'h0000);
    endproperty
    a_halt_zero: assert property (p_halt_zero) else $error("halted prescaler not zero");

    property p_hi_step;
        @(posedge clk) disable iff (!rst_n)
            (mode == CSP_ACTIVE_HI) |=> (st_q.sps == 13'($past(st_q.sps) + 13'h0001));
    endproperty
    a_hi_step: assert property (p_hi_step) else $error("prescaler missed a step");

    property p_wrap;
        @(posedge clk) disable iff (!rst_n)
            (mode == CSP_ACTIVE_HI && st_q.sps == 13'h1FFF) |=> (st_q.sps == 13'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("prescaler did not wrap");

    property p_start;
        @(posedge clk) $rose(rst_n) && mode == CSP_ACTIVE_HI |-> (st_q.sps == 13'h0000);
    endproperty
    a_start: assert property (p_start) else $error("prescaler not cleared by reset");

    property p_med_hold;
        @(posedge clk) disable iff (!rst_n)
            (mode == CSP_ACTIVE_MED && !osc_tick) |=> $stable(st_q.sps);
    endproperty
    a_med_hold: assert property (p_med_hold) else $error("medium-speed count moved");

    property p_stop_guard;
        @(posedge clk) disable iff (!rst_n)
            (osc_wr && osc_wdata[7] && mode == CSP_SUBACTIVE && !st_q.sub_stop)
            |=> !subclk_osc_stop;
    endproperty
    a_stop_guard: assert property (p_stop_guard) else $error("stop set outside active");

    property p_sel_keep;
        @(posedge clk) disable iff (!rst_n)
            !st_q.in_reset |=> $stable(st_q.sel_lat);
    endproperty
    a_sel_keep: assert property (p_sel_keep) else $error("selection changed");

    property p_flags;
        @(posedge clk) disable iff (!rst_n)
            (st_q.in_reset && st_q.rel_cnt == SEL_LATCH_CNT && !rst_keep_sel)
            |=> (oscillator_control_reg[2] == $past(clock_select_pin, 3)
                 && oscillator_control_reg[1] == $past(clock_select_pin, 3)
                 && sysosc_enable == !$past(clock_select_pin, 3));
    endproperty
    a_flags: assert property (p_flags) else $error("flag mismatch");

    property p_sub_stop;
        @(posedge clk) disable iff (!rst_n)
            (subclk_osc_stop && !tb_clear) |=> $stable(w_cnt);
    endproperty
    a_sub_stop: assert property (p_sub_stop) else $error("subclock ran while stopped");

    c_wrap: cover property (@(posedge clk) st_q.sps == 13'h1FFF ##1 st_q.sps == 13'h0000);
    c_med:  cover property (@(posedge clk) mode == CSP_ACTIVE_MED && sys_adv);
    c_tbclr: cover property (@(posedge clk) tb_clear && w_cnt != 5'h00);
    c_onchip: cover property (@(posedge clk) onchip_osc_enable);

endmodule : csp_top

// ### tb/csp_far_model.sv
// Far-side model: oscillator and subclock pin levels seen by the block.
// Assumes clk is the 100 MHz bench clock; slow clocks are counted from it.
`timescale 1ns/1ns

module csp_far_model (
    input  wire logic clk,          // Bench clock
    input  wire logic sub_stop,     // Subclock oscillator stop request
    output logic      osc_clk_pin,  // Oscillator clock level, period 4 clocks
    output logic      subclk_pin    // Subclock level, period 6 clocks
);
    logic       osc_half;
    logic [1:0] sub_cnt;

    initial begin
        osc_clk_pin = 1'b0;
        subclk_pin  = 1'b0;
        osc_half    = 1'b0;
        sub_cnt     = 2'h0;
    end

    // ==========================================================
    // Oscillator runs free; subclock stands low while stopped
    always @(posedge clk) begin
        osc_half <= ~osc_half;
        if (osc_half) begin
            osc_clk_pin <= ~osc_clk_pin;
        end
        if (sub_stop) begin
            subclk_pin <= 1'b0;
            sub_cnt    <= 2'h0;
        end else if (sub_cnt == 2'h2) begin
            subclk_pin <= ~subclk_pin;
            sub_cnt    <= 2'h0;
        end else begin
            sub_cnt <= sub_cnt + 2'h1;
        end
    end
endmodule : csp_far_model

// ### tb/csp_top_tb.sv
// Self-checking bench for the clock select and prescaler block.
// Assumes the far-side model supplies osc (4 clocks) and subclock (6 clocks).
`timescale 1ns/1ns

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end

module csp_top_tb import csp_pkg::*; ;
    logic       clk, rst_n, rst_keep_sel, clock_select_pin, osc_clk_pin, subclk_pin;
    logic       osc_wr, timer_a_mode_wr, sysosc_enable, onchip_osc_enable, subclk_osc_stop;
    logic [7:0] osc_wdata, oscillator_control_reg;
    logic [3:2] timer_a_mode_wdata;
    csp_mode_t  mode;
    csp_mdiv_t  med_div;
    csp_taps_t  taps;
    int         bad_count, total_checks, cyc, n;
    logic [12:0] s;
    csp_mode_t  lp[4] = '{CSP_STANDBY, CSP_WATCH, CSP_SUBACTIVE, CSP_SUBSLEEP};

    csp_top dut (.clk(clk), .rst_n(rst_n), .rst_keep_sel(rst_keep_sel),
        .clock_select_pin(clock_select_pin), .osc_clk_pin(osc_clk_pin),
        .subclk_pin(subclk_pin), .mode(mode), .med_div(med_div), .osc_wr(osc_wr),
        .osc_wdata(osc_wdata), .timer_a_mode_wr(timer_a_mode_wr),
        .timer_a_mode_wdata(timer_a_mode_wdata),
        .oscillator_control_reg(oscillator_control_reg), .sysosc_enable(sysosc_enable),
        .onchip_osc_enable(onchip_osc_enable), .subclk_osc_stop(subclk_osc_stop),
        .taps(taps));
    csp_far_model far (.clk(clk), .sub_stop(subclk_osc_stop),
        .osc_clk_pin(osc_clk_pin), .subclk_pin(subclk_pin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Tasks
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    // Pin held steady for the whole reset, well past the synchroniser depth
    task automatic do_reset(input logic pin);
        @(posedge clk);
        rst_n <= 1'b0;
        clock_select_pin <= pin;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) step;
    endtask : do_reset

    task automatic wr_osc(input logic [7:0] d);
        @(posedge clk);
        osc_wr <= 1'b1;
        osc_wdata <= d;
        @(posedge clk);
        osc_wr <= 1'b0;
        #1;
    endtask : wr_osc

    task automatic wr_timer_a(input logic [1:0] b);
        @(posedge clk);
        timer_a_mode_wr <= 1'b1;
        timer_a_mode_wdata <= b;
        @(posedge clk);
        timer_a_mode_wr <= 1'b0;
        #1;
    endtask : wr_timer_a

    function automatic logic [12:0] cur(input bit w);
        return w ? {8'h00, taps.watch_taps} : taps.sys_taps;
    endfunction : cur

    // Cycles between two successive count changes; bounded so a stall shows
    task automatic gap(input bit w, output int k);
        logic [12:0] v;
        k = 0;
        v = cur(w);
        while (cur(w) === v && k < 5000) begin step; k++; end
        v = cur(w);
        k = 0;
        while (cur(w) === v && k < 5000) begin step; k++; end
    endtask : gap

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            end_sim;
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        {rst_n, rst_keep_sel, clock_select_pin, osc_wr, timer_a_mode_wr} = '0;
        osc_wdata = 8'h00;
        timer_a_mode_wdata = 2'h0;
        mode = CSP_ACTIVE_HI;
        med_div = CSP_MDIV16;
        {bad_count, total_checks, cyc} = '0;
        do_reset(1'b0);
        `CHK(oscillator_control_reg, 8'h00)
        `CHK({sysosc_enable, onchip_osc_enable}, 2'b10)
        `CHK(taps.sys_taps, 13'h0003)
        `CHK(taps.watch_taps, 5'h00)
        repeat (4) begin
            step;
            `CHK(taps.sys_ticks[0], taps.sys_taps[0])
        end
        s = taps.sys_taps;
        repeat (10) step;
        `CHK(taps.sys_taps, s + 13'h000A)
        s = taps.sys_taps;
        repeat (8192) step;
        `CHK(taps.sys_taps, s)
        foreach (lp[i]) begin
            @(posedge clk) mode <= lp[i];
            repeat (3) step;
            `CHK(taps.sys_taps, 13'h0000)
            gap(1'b1, n);
            `CHK(n, 24)
        end
        @(posedge clk) mode <= CSP_ACTIVE_MED;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) med_div <= csp_mdiv_t'(i[1:0]);
            gap(1'b0, n);
            gap(1'b0, n);
            `CHK(n, 64 << i)
        end
        @(posedge clk) mode <= CSP_ACTIVE_HI;
        do gap(1'b1, n); while (taps.watch_taps === 5'h00);
        s = cur(1'b1);
        wr_timer_a(2'b01);
        `CHK(cur(1'b1), s)
        wr_timer_a(2'b11);
        `CHK(taps.watch_taps, 5'h00)
        wr_osc(8'hFF);
        `CHK(oscillator_control_reg, 8'hB8)
        `CHK(subclk_osc_stop, 1'b1)
        s = cur(1'b1);
        repeat (100) step;
        `CHK(cur(1'b1), s)
        wr_osc(8'h00);
        `CHK(oscillator_control_reg, 8'h00)
        // Restarted subclock is left to settle before use
        repeat (30) step;
        @(posedge clk) mode <= CSP_SUBACTIVE;
        wr_osc(8'h80);
        `CHK(subclk_osc_stop, 1'b0)
        @(posedge clk) mode <= CSP_ACTIVE_HI;
        do_reset(1'b1);
        `CHK(oscillator_control_reg, 8'h06)
        `CHK({sysosc_enable, onchip_osc_enable}, 2'b01)
        // Watchdog-style reset with the pin flipped must keep the selection
        @(posedge clk) rst_keep_sel <= 1'b1;
        do_reset(1'b0);
        `CHK(oscillator_control_reg, 8'h06)
        `CHK({sysosc_enable, onchip_osc_enable}, 2'b01)
        @(posedge clk) rst_keep_sel <= 1'b0;
        end_sim;
    end
endmodule : csp_top_tb
